/* File: src/scd_dma.sv */
// Single-channel block DMA with count and address timers
//
// Functional notes
// RQ1 - Enable bit gates whole transfer engine
// RQ2 - Start bit starts, suspends; hardware clears at end
// RQ3 - Completion flag interrupt gated by its enable
// RQ4 - Completion flag set at end, software clears
// RQ5 - Software writes zeros to reserved bits
// RQ6 - Configuration top bits hold interrupt priority
// RQ7 - Copy each moved byte to CRC when enabled
// RQ8 - Trigger field picks software or event start
// RQ9 - Configuration bit 0 enables loop operation
// RQ10 - Upper path nibble selects source
// RQ11 - Lower path nibble selects destination
// RQ12 - Count timer overflow flag sticks until cleared
// RQ13 - Count timer clock source select
// RQ14 - Count timer overflow interrupt gated by enable
// RQ15 - Count timer runs only with run bit; with the enable bit set it counts transactions without it
// RQ16 - Count timer gate source select
// RQ17 - Address timer overflow flag sticks until cleared
// RQ18 - Address timer clock source select
// RQ19 - Address timer overflow interrupt gated by enable
// RQ20 - Address timer runs only with run bit; with the enable bit set it counts transactions without it
// RQ21 - Address timer gate source select
// RQ22 - Count wrap ends transfer, flags, reloads both
// RQ23 - Address counter increments every transaction
// RQ24 - Selected trigger event sets start bit
// RQ25 - Loop mode reloads and keeps serving
// RQ26 - Free timers count selected gated clock events
`timescale 1ns/10ps
module scd_dma (
	input  wire logic       core_clk_i,	// System clock
	input  wire logic       reset_i,	// Async reset, high
	input  wire logic [3:0] sfr_page_i,	// Register page
	input  wire logic [7:0] sfr_addr_i,	// Register address
	input  wire logic       sfr_wr_i,	// Write strobe
	input  wire logic [7:0] sfr_wdata_i,	// Write data
	input  wire logic       sfr_rd_i,	// Read strobe
	output logic      [7:0] sfr_rdata_o,	// Read data, next cycle
	input  wire logic       xfer_req_i,	// Selected pair ready
	input  wire logic [7:0] xfer_rdata_i,	// Source byte
	output logic      [3:0] src_sel_o,	// Source select
	output logic      [3:0] dst_sel_o,	// Destination select
	output logic            xfer_rd_o,	// Source read strobe
	output logic            xfer_wr_o,	// Destination write strobe
	output logic      [7:0] xfer_wdata_o,	// Byte to destination
	output logic     [15:0] expanded_ram_addr_o,	// Expanded RAM address
	output logic            crc_wr_o,	// CRC copy strobe
	output logic      [7:0] crc_data_o,	// CRC copy byte
	output logic            dma_irq_o,	// Shared interrupt request
	output logic      [1:0] irq_priority_o,	// Interrupt priority
	input  wire logic       ext_irq0_event_i,	// On-chip event
	input  wire logic       ext_irq1_event_i,	// On-chip event
	input  wire logic       ext_irq2_event_i,	// On-chip event
	input  wire logic       break_mod1_event_i,	// On-chip event
	input  wire logic       keypad_event_i,	// On-chip event
	input  wire logic       timer2_ext_input_i,	// On-chip selection
	input  wire logic       timer3_ext_input_i,	// On-chip selection
	input  wire logic       count_timer_pin_i,	// Pin, asynchronous
	input  wire logic       address_timer_pin_i	// Pin, asynchronous
);

	// Register state
	logic [3:0]  ctrl_q, ctrl_d;	// Enable, start, ie, flag
	logic [7:0]  cfg_q, cfg_d;	// Configuration
	logic [7:0]  path_q, path_d;	// Source and destination
	logic [7:0]  tcon_q [2];	// Timer controls
	logic [7:0]  tcon_d [2];	// Next timer controls
	logic [15:0] rl_q [2];	// Reload registers
	logic [15:0] rl_d [2];	// Next reload registers
	logic [3:0]  div_q, div_d;	// Prescaler

	// Transfer state
	scd_pkg::scd_state_t st_q, st_d;	// Transfer state
	logic [7:0]  byte_q, byte_d;	// Moved byte
	logic [15:0] addr_q, addr_d;	// Latched address
	logic        rd_q, wr_q, crc_q;	// Strobes
	logic        irq_q, irq_d;	// Interrupt output
	logic [7:0]  rdat_q, rdat_d;	// Read data

	// Timer wiring
	logic        tick [2];	// Count enable per timer
	logic        ovf [2];	// Overflow per timer
	logic [15:0] cnt [2];	// Current values
	logic        wlo [2], whi [2];	// Byte writes
	logic        inc;	// Transaction done
	logic        end_evt;	// End of transfer
	logic        tick12;	// Prescaler tick
	logic        path_ok;	// Legal path
	logic        trig_evt;	// Selected trigger
	logic        go;	// Start a transaction
	logic [1:0]  pin_w;	// Raw timer pins
	logic [3:0]  pg_w [2];	// Timer pages

	// Field views
	wire         en    = ctrl_q[scd_pkg::CR_EN];
	wire         start = ctrl_q[scd_pkg::CR_START];
	wire [3:0]   src   = path_q[7:4];
	wire [3:0]   dst   = path_q[3:0];
	wire [1:0]   trg   = {cfg_q[scd_pkg::CG_TRG_H], cfg_q[scd_pkg::CG_TRG_L]};

	assign pin_w = {address_timer_pin_i, count_timer_pin_i};
	// Full page compare; page 4 shares no low bits with page 3
	assign pg_w[0] = scd_pkg::PG_CNT;
	assign pg_w[1] = scd_pkg::PG_ADR;

	// Source and destination must both be real, non-reserved
	// codes; same-memory copies are not supported
	always_comb
	begin
		path_ok = (src != scd_pkg::PATH_OFF) && (dst != scd_pkg::PATH_OFF) //RQ10
		    && (src != scd_pkg::PATH_CRC) && (dst != scd_pkg::PATH_RSVD) //RQ11
		    && !(src == scd_pkg::PATH_EXPANDED_RAM && dst == scd_pkg::PATH_EXPANDED_RAM)
		    && !(src == scd_pkg::PATH_EMB && dst == scd_pkg::PATH_EMB);
	end

	// Trigger event mux
	always_comb
	begin
		case (scd_pkg::scd_trg_t'(trg)) //RQ8
			scd_pkg::TRG_INT2: trig_evt = ext_irq2_event_i;
			scd_pkg::TRG_BRK:  trig_evt = break_mod1_event_i;
			scd_pkg::TRG_KEY:  trig_evt = keypad_event_i;
			default:           trig_evt = 1'b0;
		endcase
	end

	// Shared divide-by-12 prescaler
	always_comb
	begin
		tick12 = (div_q == scd_pkg::DIV12_LAST);
		div_d  = tick12 ? 4'h0 : div_q + 4'h1;
	end

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			div_q <= 4'h0;
		else
			div_q <= div_d;
	end

	// Per-timer pin sync, clock and gate selection, counter
	for (genvar g = 0; g < 2; g++)
	begin : g_tmr
		logic [2:0] pin_q, pin_d;	// Sync stages plus edge history
		logic       clk_evt;	// Selected clock event
		logic       gate_ok;	// Selected gate level
		logic [7:0] tc;	// Control view

		// Two stages before use; third only for edge detect
		always_comb
		begin
			pin_d = {pin_q[1:0], pin_w[g]};
		end

		always_ff @(posedge core_clk_i or posedge reset_i)
		begin
			if (reset_i)
				pin_q <= 3'h0;
			else
				pin_q <= pin_d;
		end

		// Clock and gate sources; the two timers swap the
		// external selections and the gating interrupt
		always_comb
		begin
			tc = tcon_q[g];
			case (scd_pkg::scd_cks_t'(tc[scd_pkg::TC_CKS_H:scd_pkg::TC_CKS_L])) //RQ13 RQ18
				scd_pkg::CKS_DIV12: clk_evt = tick12;
				scd_pkg::CKS_PIN:   clk_evt = pin_q[2] & ~pin_q[1];
				scd_pkg::CKS_SYS:   clk_evt = 1'b1;
				default: clk_evt = (g == 0) ? timer2_ext_input_i
				                            : timer3_ext_input_i;
			endcase
			case (scd_pkg::scd_gat_t'(tc[scd_pkg::TC_GAT_H:scd_pkg::TC_GAT_L])) //RQ16 RQ21
				scd_pkg::GAT_OFF:  gate_ok = 1'b1;
				scd_pkg::GAT_INTX: gate_ok = (g == 0) ? ~ext_irq0_event_i
				                                      : ~ext_irq1_event_i;
				scd_pkg::GAT_INT2: gate_ok = ~ext_irq2_event_i;
				default: gate_ok = (g == 0) ? timer3_ext_input_i
				                            : timer2_ext_input_i;
			endcase
			// DMA mode advances on transactions only
			if (en)
				tick[g] = inc; //RQ22 RQ23
			else
				tick[g] = tc[scd_pkg::TC_RUN] & gate_ok & clk_evt; //RQ15 RQ20 RQ26
		end

		scd_timer u_tmr (
			.core_clk_i  (core_clk_i),
			.reset_i     (reset_i),
			.count_i     (tick[g]),
			.wr_lo_i     (wlo[g]),
			.wr_hi_i     (whi[g]),
			.wdata_i     (sfr_wdata_i),
			.reload_i    (end_evt),
			.reload_val_i(rl_q[g]),
			.cnt_o       (cnt[g]),
			.ovf_o       (ovf[g])
		);
	end

	// Byte write decode for the live counters
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			wlo[i] = sfr_wr_i && sfr_page_i == pg_w[i]
			    && sfr_addr_i == scd_pkg::A_TL;
			whi[i] = sfr_wr_i && sfr_page_i == pg_w[i]
			    && sfr_addr_i == scd_pkg::A_TH;
		end
	end

	// Transaction sequencing: read source, then write destination
	always_comb
	begin
		st_d    = st_q;
		byte_d  = byte_q;
		addr_d  = addr_q;
		inc     = 1'b0;
		go      = en && start && xfer_req_i && path_ok; //RQ1 RQ2
		end_evt = 1'b0;
		case (st_q)
			scd_pkg::ST_IDLE:
			begin
				// Suspend only takes effect between transactions
				if (go)
				begin
					st_d   = scd_pkg::ST_READ;
					addr_d = cnt[1];
				end
			end
			scd_pkg::ST_READ:
			begin
				st_d   = scd_pkg::ST_WRITE;
				byte_d = xfer_rdata_i;
				inc    = 1'b1; //RQ22 RQ23
				end_evt = en && (&cnt[0]); //RQ22
			end
			scd_pkg::ST_WRITE:
			begin
				st_d = scd_pkg::ST_IDLE;
			end
			default:
			begin
				st_d = scd_pkg::ST_IDLE;
			end
		endcase
		// Clearing enable stops at once
		if (!en)
			st_d = scd_pkg::ST_IDLE; //RQ1
	end

	// Transfer registers and output strobes
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_q   <= scd_pkg::ST_IDLE;
			byte_q <= scd_pkg::RST_BYTE;
			addr_q <= scd_pkg::RST_WORD;
			rd_q   <= 1'b0;
			wr_q   <= 1'b0;
			crc_q  <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			byte_q <= byte_d;
			addr_q <= addr_d;
			rd_q   <= (st_d == scd_pkg::ST_READ);
			wr_q   <= (st_d == scd_pkg::ST_WRITE);
			crc_q  <= (st_d == scd_pkg::ST_WRITE) && cfg_q[scd_pkg::CG_CRC] //RQ7
			    && (dst != scd_pkg::PATH_CRC);
		end
	end

	// Register writes and hardware updates; hardware sets win
	always_comb
	begin
		ctrl_d = ctrl_q;
		cfg_d  = cfg_q;
		path_d = path_q;
		for (int i = 0; i < 2; i++)
		begin
			tcon_d[i] = tcon_q[i];
			rl_d[i]   = rl_q[i];
		end
		// End of transfer clears start unless looping
		if (end_evt && !cfg_q[scd_pkg::CG_LOOP]) //RQ9 RQ25
			ctrl_d[scd_pkg::CR_START] = 1'b0; //RQ2 RQ22
		if (sfr_wr_i)
		begin
			if (sfr_page_i <= scd_pkg::PG_CTRL_MAX && sfr_addr_i == scd_pkg::A_CTRL)
				ctrl_d = sfr_wdata_i[3:0]; //RQ2 RQ4 RQ5
			else if (sfr_page_i == scd_pkg::PG_CFG && sfr_addr_i == scd_pkg::A_CFG)
				cfg_d = sfr_wdata_i & scd_pkg::CG_WMASK; //RQ5 RQ6
			else if (sfr_page_i == scd_pkg::PG_PATH && sfr_addr_i == scd_pkg::A_PATH)
				path_d = sfr_wdata_i; //RQ10 RQ11
			else
			begin
				for (int i = 0; i < 2; i++)
				begin
					if (sfr_page_i == pg_w[i])
					begin
						if (sfr_addr_i == scd_pkg::A_TCON)
							tcon_d[i] = sfr_wdata_i & scd_pkg::TC_WMASK;
						else if (sfr_addr_i == scd_pkg::A_TRL)
							rl_d[i][7:0] = sfr_wdata_i;
						else if (sfr_addr_i == scd_pkg::A_TRH)
							rl_d[i][15:8] = sfr_wdata_i;
					end
				end
			end
		end
		// Event sets come last so a clear in the same cycle loses
		if (en && scd_pkg::scd_trg_t'(trg) != scd_pkg::TRG_SW && trig_evt)
			ctrl_d[scd_pkg::CR_START] = 1'b1; //RQ24
		if (end_evt)
			ctrl_d[scd_pkg::CR_FLAG] = 1'b1; //RQ4 RQ22
		for (int i = 0; i < 2; i++)
		begin
			if (ovf[i])
				tcon_d[i][scd_pkg::TC_TF] = 1'b1; //RQ12 RQ17
		end
	end

	// Register file
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ctrl_q <= scd_pkg::RST_BYTE[3:0];
			cfg_q  <= scd_pkg::RST_BYTE;
			path_q <= scd_pkg::RST_BYTE;
			for (int i = 0; i < 2; i++)
			begin
				tcon_q[i] <= scd_pkg::RST_BYTE;
				rl_q[i]   <= scd_pkg::RST_WORD;
			end
		end
		else
		begin
			ctrl_q <= ctrl_d;
			cfg_q  <= cfg_d;
			path_q <= path_d;
			for (int i = 0; i < 2; i++)
			begin
				tcon_q[i] <= tcon_d[i];
				rl_q[i]   <= rl_d[i];
			end
		end
	end

	// Read mux and shared interrupt; unmapped reads give zero
	always_comb
	begin
		rdat_d = scd_pkg::RST_BYTE;
		if (sfr_rd_i)
		begin
			if (sfr_page_i <= scd_pkg::PG_CTRL_MAX && sfr_addr_i == scd_pkg::A_CTRL)
				rdat_d = {4'h0, ctrl_q};
			else if (sfr_page_i == scd_pkg::PG_CFG && sfr_addr_i == scd_pkg::A_CFG)
				rdat_d = cfg_q;
			else if (sfr_page_i == scd_pkg::PG_PATH && sfr_addr_i == scd_pkg::A_PATH)
				rdat_d = path_q;
			else
			begin
				for (int i = 0; i < 2; i++)
				begin
					if (sfr_page_i == pg_w[i])
					begin
						if (sfr_addr_i == scd_pkg::A_TCON)
							rdat_d = tcon_q[i];
						else if (sfr_addr_i == scd_pkg::A_TRL)
							rdat_d = rl_q[i][7:0];
						else if (sfr_addr_i == scd_pkg::A_TRH)
							rdat_d = rl_q[i][15:8];
						else if (sfr_addr_i == scd_pkg::A_TL)
							rdat_d = cnt[i][7:0];
						else if (sfr_addr_i == scd_pkg::A_TH)
							rdat_d = cnt[i][15:8];
					end
				end
			end
		end
		irq_d = (ctrl_q[scd_pkg::CR_FLAG] & ctrl_q[scd_pkg::CR_IE]) //RQ3
		    | (tcon_q[0][scd_pkg::TC_TF] & tcon_q[0][scd_pkg::TC_IE]) //RQ14
		    | (tcon_q[1][scd_pkg::TC_TF] & tcon_q[1][scd_pkg::TC_IE]); //RQ19
	end

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rdat_q <= scd_pkg::RST_BYTE;
			irq_q  <= 1'b0;
		end
		else
		begin
			rdat_q <= rdat_d;
			irq_q  <= irq_d;
		end
	end

	// Outputs, all from flops
	assign sfr_rdata_o    = rdat_q;
	assign dma_irq_o      = irq_q;
	assign irq_priority_o = cfg_q[scd_pkg::CG_PRIO_H:scd_pkg::CG_PRIO_L]; //RQ6
	assign src_sel_o      = path_q[7:4];
	assign dst_sel_o      = path_q[3:0];
	assign xfer_rd_o      = rd_q;
	assign xfer_wr_o      = wr_q;
	assign xfer_wdata_o   = byte_q;
	assign expanded_ram_addr_o    = addr_q;
	assign crc_wr_o       = crc_q;
	assign crc_data_o     = byte_q;

endmodule : scd_dma

/* File: src/scd_pkg.sv */
// Package with register map, field layout and encodings of the DMA block
package scd_pkg;

	// Register pages and addresses
	localparam logic [3:0] PG_CTRL_MAX = 4'h7;	// Control seen on pages 0..7
	localparam logic [3:0] PG_CFG      = 4'h8;	// Configuration page
	localparam logic [3:0] PG_PATH     = 4'h9;	// Path select page
	localparam logic [3:0] PG_CNT      = 4'h3;	// Count timer page
	localparam logic [3:0] PG_ADR      = 4'h4;	// Address timer page
	localparam logic [7:0] A_CTRL      = 8'h04;	// dma_control
	localparam logic [7:0] A_CFG       = 8'h94;	// dma_configuration
	localparam logic [7:0] A_PATH      = 8'h94;	// dma_path_select
	localparam logic [7:0] A_TCON      = 8'hc8;	// Timer control
	localparam logic [7:0] A_TRL       = 8'hca;	// Timer reload low
	localparam logic [7:0] A_TRH       = 8'hcb;	// Timer reload high
	localparam logic [7:0] A_TL        = 8'hcc;	// Timer low byte
	localparam logic [7:0] A_TH        = 8'hcd;	// Timer high byte

	// Reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;	// All registers clear
	localparam logic [15:0] RST_WORD = 16'h0000;	// Counters and reloads

	// dma_control fields
	localparam int CR_EN    = 3;	// transfer_enable_bit
	localparam int CR_START = 2;	// transfer_start_bit
	localparam int CR_IE    = 1;	// completion_irq_enable
	localparam int CR_FLAG  = 0;	// completion_flag

	// dma_configuration fields
	localparam int CG_PRIO_H = 7;	// irq_priority_high
	localparam int CG_PRIO_L = 6;	// irq_priority_low
	localparam int CG_CRC    = 5;	// crc_copy_enable
	localparam int CG_TRG_H  = 3;	// trigger_select_hi
	localparam int CG_TRG_L  = 2;	// trigger_select_lo
	localparam int CG_LOOP   = 0;	// loop_enable
	localparam logic [7:0] CG_WMASK = 8'hed;	// Reserved bits 4 and 1

	// Timer control fields
	localparam int TC_TF    = 7;	// Overflow flag
	localparam int TC_CKS_H = 5;	// Clock select high
	localparam int TC_CKS_L = 4;	// Clock select low
	localparam int TC_IE    = 3;	// Interrupt enable
	localparam int TC_RUN   = 2;	// Run bit
	localparam int TC_GAT_H = 1;	// Gate select high
	localparam int TC_GAT_L = 0;	// Gate select low
	localparam logic [7:0] TC_WMASK = 8'hbf;	// Reserved bit 6

	// Timer clock sources
	typedef enum logic [1:0] {
		CKS_DIV12 = 2'h0,
		CKS_PIN   = 2'h1,
		CKS_SYS   = 2'h2,
		CKS_EXT   = 2'h3
	} scd_cks_t;

	// Timer gate sources
	typedef enum logic [1:0] {
		GAT_OFF  = 2'h0,
		GAT_INTX = 2'h1,
		GAT_INT2 = 2'h2,
		GAT_EXT  = 2'h3
	} scd_gat_t;

	// Start trigger sources
	typedef enum logic [1:0] {
		TRG_SW   = 2'h0,
		TRG_INT2 = 2'h1,
		TRG_BRK  = 2'h2,
		TRG_KEY  = 2'h3
	} scd_trg_t;

	// Path codes of note
	localparam logic [3:0] PATH_OFF  = 4'h0;	// Disabled
	localparam logic [3:0] PATH_EMB  = 4'hb;	// External bus
	localparam logic [3:0] PATH_CRC  = 4'hd;	// CRC dest, reserved source
	localparam logic [3:0] PATH_RSVD = 4'h9;	// Reserved destination
	localparam logic [3:0] PATH_EXPANDED_RAM = 4'hf;	// Expanded RAM

	// Divide-by-12 prescaler terminal count
	localparam logic [3:0] DIV12_LAST = 4'hb;

	// Transfer state machine
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b10
	} scd_state_t;

endpackage : scd_pkg

/* File: src/scd_timer.sv */
// Sixteen-bit up counter with byte writes and auto reload
`timescale 1ns/10ps
module scd_timer (
	input  wire logic        core_clk_i,	// System clock
	input  wire logic        reset_i,	// Async reset, high
	input  wire logic        count_i,	// Advance by one
	input  wire logic        wr_lo_i,	// Write low byte
	input  wire logic        wr_hi_i,	// Write high byte
	input  wire logic [7:0]  wdata_i,	// Write data
	input  wire logic        reload_i,	// Forced reload
	input  wire logic [15:0] reload_val_i,	// Base value
	output logic      [15:0] cnt_o,	// Current value
	output logic             ovf_o	// Wrap pulse
);

	logic [15:0] cnt_q;	// Counter
	logic [15:0] cnt_d;	// Next counter

	// Software write wins, then forced reload, then counting
	always_comb
	begin
		cnt_d = cnt_q;
		ovf_o = 1'b0;
		if (wr_lo_i || wr_hi_i)
		begin
			if (wr_lo_i)
				cnt_d[7:0] = wdata_i;
			if (wr_hi_i)
				cnt_d[15:8] = wdata_i;
		end
		else if (reload_i)
			cnt_d = reload_val_i;
		else if (count_i)
		begin
			// Wrap from all ones reloads the base
			if (&cnt_q)
			begin
				cnt_d = reload_val_i;
				ovf_o = 1'b1;
			end
			else
				cnt_d = cnt_q + 16'h0001;
		end
	end

	// Counter register
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			cnt_q <= scd_pkg::RST_WORD;
		else
			cnt_q <= cnt_d;
	end

	assign cnt_o = cnt_q;

endmodule : scd_timer

/* File: verif/scd_dma_props.sv */
// Port-level checks of the DMA block, attached by bind
`timescale 1ns/10ps
module scd_dma_chk (
	input wire logic        core_clk_i,	// System clock
	input wire logic        reset_i,	// Async reset
	input wire logic        sfr_wr_i,	// Write strobe
	input wire logic        sfr_rd_i,	// Read strobe
	input wire logic  [7:0] sfr_rdata_o,	// Read data
	input wire logic        xfer_req_i,	// Pair ready
	input wire logic  [7:0] xfer_rdata_i,	// Source byte
	input wire logic  [3:0] src_sel_o,	// Source nibble
	input wire logic  [3:0] dst_sel_o,	// Dest nibble
	input wire logic        xfer_rd_o,	// Read strobe
	input wire logic        xfer_wr_o,	// Write strobe
	input wire logic  [7:0] xfer_wdata_o,	// Dest byte
	input wire logic [15:0] expanded_ram_addr_o,	// RAM address
	input wire logic        crc_wr_o,	// CRC strobe
	input wire logic  [7:0] crc_data_o,	// CRC byte
	input wire logic  [1:0] irq_priority_o	// Priority
);
	// One clock domain for every check
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	// Read strobe not cut short by a register write
	sequence s_head;
		xfer_rd_o && !sfr_wr_i;
	endsequence

	// Write half, then the idle cycle
	sequence s_tail;
		xfer_wr_o && !xfer_rd_o ##1 !xfer_rd_o;
	endsequence

	a_xact_shape: assert property (s_head |=> s_tail)
		else $error("transaction shape broken");
	a_req_first: assert property (xfer_rd_o |-> $past(xfer_req_i))
		else $error("read strobe without request");
	a_wdata_src: assert property (xfer_wr_o |->
		xfer_wdata_o == $past(xfer_rdata_i))
		else $error("written byte differs from source");
	a_crc_copy: assert property (crc_wr_o |-> xfer_wr_o &&
		crc_data_o == xfer_wdata_o && dst_sel_o != scd_pkg::PATH_CRC)
		else $error("bad copy to checksum unit");
	a_path_legal: assert property (xfer_rd_o |->
		src_sel_o != scd_pkg::PATH_OFF && dst_sel_o != scd_pkg::PATH_OFF
		&& dst_sel_o != scd_pkg::PATH_RSVD && src_sel_o != scd_pkg::PATH_CRC)
		else $error("transfer on illegal path");
	a_addr_hold: assert property (xfer_wr_o |-> $stable(expanded_ram_addr_o))
		else $error("address moved inside transaction");
	a_prio_quiet: assert property (!sfr_wr_i && !$past(sfr_wr_i) |->
		$stable(irq_priority_o))
		else $error("priority changed without write");
	a_sel_quiet: assert property (!sfr_wr_i && !$past(sfr_wr_i) |->
		$stable(src_sel_o) && $stable(dst_sel_o))
		else $error("path changed without write");
	a_rdata_idle: assert property (sfr_rdata_o != 8'h00 |-> $past(sfr_rd_i))
		else $error("read data outside read answer");
endmodule : scd_dma_chk

/* File: verif/scd_peer.sv */
// Far-side model: byte source and sink that may stall
`timescale 1ns/10ps
module scd_peer (
	input  wire logic       core_clk_i,	// System clock
	input  wire logic       reset_i,	// Async reset, high
	input  wire logic       slow_i,	// Offer data half the time
	input  wire logic [7:0] base_i,	// First byte of stream
	input  wire logic       rd_i,	// Source read strobe
	output logic            req_o,	// Source and sink ready
	output logic      [7:0] rdata_o	// Source byte
);
	logic [7:0] idx_q;	// Bytes handed over
	logic [7:0] idx_d;	// Next count
	logic [1:0] ph_q;	// Stall phase
	logic [1:0] ph_d;	// Next phase

	// Advance on each read; phase runs free
	always_comb
	begin
		idx_d = idx_q + {7'h00, rd_i};
		ph_d  = ph_q + 2'h1;
	end

	// Register state
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			idx_q <= 8'h00;
			ph_q  <= 2'h0;
		end
		else
		begin
			idx_q <= idx_d;
			ph_q  <= ph_d;
		end
	end

	// Slow peer ready in half its phases only
	assign req_o = !slow_i || ph_q[1];
	// Valid only under the strobe, so a late sample shows
	assign rdata_o = rd_i ? base_i + idx_q : ~(base_i + idx_q);
endmodule : scd_peer

/* File: verif/test_single_channel_dma_with_timers.sv */
// Self-checking bench for the single-channel DMA block
`timescale 1ns/10ps
module test_single_channel_dma_with_timers;
	logic        core_clk_i, reset_i, sfr_wr_i, sfr_rd_i;	// Clock, bus
	logic  [3:0] sfr_page_i, src_sel_o, dst_sel_o;	// Page, path
	logic  [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;	// Bus data
	logic        xfer_req_i, xfer_rd_o, xfer_wr_o, crc_wr_o;	// Strobes
	logic  [7:0] xfer_rdata_i, xfer_wdata_o, crc_data_o;	// Bytes
	logic [15:0] expanded_ram_addr_o;	// RAM address
	logic        dma_irq_o, ext_irq2_event_i, slow, rd_seen_q;	// Misc
	logic  [1:0] irq_priority_o;	// Priority
	logic  [7:0] ev, alo, pbase;	// Side events, bases
	logic [31:0] seed;	// Random state, main sequence
	logic [31:0] mix = 32'h0c8a;	// Random state, side events
	logic [31:0] rd_q[$];	// Expected reads
	logic [31:0] wr_q[$];	// Expected writes
	int          nb, xa, cyc, err_total, cmp_count;	// Counters
	// Reset table: page and address, last one unmapped
	localparam logic [11:0] RTAB [11] = '{12'h004, 12'h894, 12'h994,
		12'h3c8, 12'h4c8, 12'h3cc, 12'h3cd, 12'h3ca, 12'h3cb, 12'h4cc, 12'h0c8};

	scd_dma u_dut (
		.core_clk_i, .reset_i, .sfr_page_i, .sfr_addr_i, .sfr_wr_i,
		.sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .xfer_req_i, .xfer_rdata_i,
		.src_sel_o, .dst_sel_o, .xfer_rd_o, .xfer_wr_o, .xfer_wdata_o,
		.expanded_ram_addr_o, .crc_wr_o, .crc_data_o, .dma_irq_o, .irq_priority_o,
		.ext_irq0_event_i(ev[0]), .ext_irq1_event_i(ev[1]), .ext_irq2_event_i,
		.break_mod1_event_i(ev[2]), .keypad_event_i(ev[3]),
		.timer2_ext_input_i(ev[4]), .timer3_ext_input_i(ev[5]),
		.count_timer_pin_i(ev[6]), .address_timer_pin_i(ev[7])
	);
	scd_peer u_peer (
		.core_clk_i, .reset_i, .slow_i(slow), .base_i(pbase),
		.rd_i(xfer_rd_o), .req_o(xfer_req_i), .rdata_o(xfer_rdata_i)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up;
		if (err_total == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	// One-cycle write pulse
	task automatic wr(input logic [3:0] pg, input logic [7:0] ad, dt);
		@(negedge core_clk_i);
		{sfr_page_i, sfr_addr_i, sfr_wdata_i, sfr_wr_i} = {pg, ad, dt, 1'b1};
		@(negedge core_clk_i);
		sfr_wr_i = 1'b0;
	endtask : wr

	// One-cycle read pulse; the answer is noted for the monitor
	task automatic rd(input logic [3:0] pg, input logic [7:0] ad, ex);
		@(negedge core_clk_i);
		{sfr_page_i, sfr_addr_i, sfr_rd_i} = {pg, ad, 1'b1};
		rd_q.push_back({24'h0, ex});
		@(negedge core_clk_i);
		sfr_rd_i = 1'b0;
	endtask : rd

	// Note one expected byte move into expanded RAM
	task automatic xact(input logic crc);
		wr_q.push_back({{8'h01, alo} + 16'(xa), pbase + 8'(nb), 7'h0, crc});
		xa++;
		nb++;
	endtask : xact

	// Bounded wait for the shared interrupt
	task automatic wait_irq;
		for (int i = 0; i < 300 && dma_irq_o !== 1'b1; i++)
			@(negedge core_clk_i);
		chk({31'h0, dma_irq_o}, 32'h1);
	endtask : wait_irq

	always #12.5 core_clk_i = ~core_clk_i;

	// Unselected event inputs wander so selection faults show
	always @(negedge core_clk_i)
	begin
		mix = xs(mix);
		ev = mix[7:0];
	end

	// Remember reads taken at this edge
	always @(posedge core_clk_i)
		rd_seen_q <= sfr_rd_i && !reset_i;

	// Monitor: oldest note against each result
	always @(negedge core_clk_i)
	begin
		if (rd_seen_q)
			chk({24'h0, sfr_rdata_o}, rd_q.size() ? rd_q.pop_front() : '1);
		if (xfer_wr_o === 1'b1)
			chk({expanded_ram_addr_o, xfer_wdata_o, 7'h0, crc_wr_o},
				wr_q.size() ? wr_q.pop_front() : '1);
	end

	// Hang guard
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			wrap_up();
		end
	end

	// Main sequence
	initial
	begin
		{core_clk_i, reset_i, sfr_wr_i, sfr_rd_i, ext_irq2_event_i} = 5'h08;
		{sfr_page_i, sfr_addr_i, sfr_wdata_i, slow} = 21'h0;
		seed = 32'h0c8a;
		repeat (5) @(negedge core_clk_i);
		reset_i = 1'b0;
		foreach (RTAB[i])
			rd(RTAB[i][11:8], RTAB[i][7:0], 8'h00);
		wr(4'h8, 8'h94, 8'hff);
		rd(4'h8, 8'h94, 8'hed);
		chk({30'h0, irq_priority_o}, 32'h3);
		seed = xs(seed);
		{pbase, alo} = seed[15:0];
		// Two bytes back to back into expanded RAM, copy on
		wr(4'h9, 8'h94, 8'h1f);
		chk({24'h0, src_sel_o, dst_sel_o}, 32'h1f);
		wr(4'h8, 8'h94, 8'h20);
		wr(4'h3, 8'hcc, 8'hfe);
		wr(4'h3, 8'hcd, 8'hff);
		for (int i = 0; i < 4; i++)
			wr(4'h4, 8'hca + 8'(i), i[0] ? 8'h01 : alo);
		xact(1'b1);
		xact(1'b1);
		wr(4'h0, 8'h04, 8'h0e);
		wait_irq();
		rd(4'h0, 8'h04, 8'h0b);
		rd(4'h3, 8'hcd, 8'h00);
		rd(4'h4, 8'hcc, alo);
		wr(4'h0, 8'h04, 8'h08);
		rd(4'h0, 8'h04, 8'h08);
		chk({31'h0, dma_irq_o}, 32'h0);
		// Event trigger, slow peer, copy off; nothing moves before it
		{xa, slow} = {32'h0, 1'b1};
		wr(4'h8, 8'h94, 8'h04);
		wr(4'h3, 8'hcc, 8'hff);
		wr(4'h3, 8'hcd, 8'hff);
		wr(4'h0, 8'h04, 8'h0a);
		repeat (8) @(negedge core_clk_i);
		xact(1'b0);
		ext_irq2_event_i = 1'b1;
		@(negedge core_clk_i);
		ext_irq2_event_i = 1'b0;
		wait_irq();
		rd(4'h0, 8'h04, 8'h0b);
		wr(4'h0, 8'h04, 8'h00);
		// Both timers free running on the system clock
		for (int p = 3; p < 5; p++)
		begin
			wr(4'(p), 8'hcc, 8'hfd);
			wr(4'(p), 8'hcd, 8'hff);
			wr(4'(p), 8'hc8, 8'h2c);
			wait_irq();
			repeat (4) @(negedge core_clk_i);
			rd(4'(p), 8'hc8, 8'hac);
			wr(4'(p), 8'hc8, 8'h00);
			rd(4'(p), 8'hc8, 8'h00);
			chk({31'h0, dma_irq_o}, 32'h0);
		end
		repeat (4) @(negedge core_clk_i);
		chk(32'(wr_q.size() + rd_q.size()), 32'h0);
		wrap_up();
	end
endmodule : test_single_channel_dma_with_timers

bind scd_dma scd_dma_chk u_chk (
	.core_clk_i, .reset_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o,
	.xfer_req_i, .xfer_rdata_i, .src_sel_o, .dst_sel_o, .xfer_rd_o,
	.xfer_wr_o, .xfer_wdata_o, .expanded_ram_addr_o, .crc_wr_o, .crc_data_o,
	.irq_priority_o
);
